// [hw/cpg_params.svh]
// constants of the glyph pattern and cursor generator
// assumes one 40 MHz clock; host logic runs on that same clock
`ifndef CPG_PARAMS_SVH
`define CPG_PARAMS_SVH

// ****************************************
// geometry
// ****************************************
`define NUM_COMMONS 16
`define NUM_SEGMENTS 100
`define CHARS_PER_LINE 20
`define DOTS_PER_ROW 5
`define USER_GLYPHS 4
`define CURSOR_ROW 4'ha
`define ROWS_ONE_LINE 5'h0b
`define ROWS_TWO_LINE 5'h10
`define LINE_ROWS 3'h7
`define LINE2_BASE 7'h40
`define ROM_BLANK 5'h00
`define ALL_DOTS 5'h1f

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 25
`define COMMON_TIME_NS 100000
`define COMMON_CYCLES (`COMMON_TIME_NS / `CLK_PERIOD_NS)
`define BLINK_TIME_NS 409600000
`define BLINK_CYCLES (`BLINK_TIME_NS / `CLK_PERIOD_NS)

`endif

// [hw/cpg_pkg.sv]
// types of the glyph pattern and cursor generator
// assumes nothing beyond the constants header
package cpg_pkg;

	// ****************************************
	// access slots
	// ****************************************
	typedef enum logic {SLOT_REFRESH, SLOT_HOST} slot_type;

endpackage

// [hw/char_pattern_cursor_gen.sv]
// glyph lookup, cursor merge and common/segment scan of the display
// assumes host write port and controls come from logic on clk
`include "cpg_params.svh"
`timescale 1ns/100ps
`default_nettype none

module char_pattern_cursor_gen
	import cpg_pkg::*;
#(
	parameter int BLINK_CYCLES = `BLINK_CYCLES,
	parameter int COMMON_CYCLES = `COMMON_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// host write port
	input wire logic host_we,
	input wire logic host_to_pattern,
	input wire logic [6:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic host_ready,
	// display control
	input wire logic two_line,
	input wire logic cursor_en,
	input wire logic blink_en,
	input wire logic [6:0] pointer_counter,
	// drivers
	output logic [`NUM_COMMONS-1:0] common_out,
	output logic [`NUM_SEGMENTS-1:0] segment_out
);

	localparam int BW = $clog2(BLINK_CYCLES);
	localparam int CW = $clog2(COMMON_CYCLES);
	localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_CYCLES - 1);
	localparam logic [CW-1:0] COMMON_LAST = CW'(COMMON_CYCLES - 1);

	// ****************************************
	// decoding helpers
	// ****************************************
	// pattern RAM index of a code and row; bits 0 and 3 drop out
	function automatic logic [5:0] glyph_index(input logic [7:0] code,
		input logic [3:0] row);
		glyph_index = {code[2:1], row};
	endfunction

	// display address of a position on a line
	function automatic logic [6:0] char_addr(input logic line,
		input logic [4:0] pos);
		char_addr = line ? (`LINE2_BASE | {2'h0, pos}) : {2'h0, pos};
	endfunction

	// ****************************************
	// storage
	// ****************************************
	logic [7:0] disp_ram_ff [128];
	logic [4:0] pram_ff [`USER_GLYPHS*16];
	slot_type slot_ff;
	logic pend_ff;
	logic pend_pat_ff;
	logic [6:0] pend_addr_ff;
	logic [7:0] pend_data_ff;
	logic nxt_pend;
	logic host_ready_ff;
	logic wr_fire;
	logic [CW-1:0] com_cnt_ff;
	logic com_step;
	logic [3:0] com_idx_ff;
	logic load_ff;
	logic latch_en;
	logic [BW-1:0] blink_cnt_ff;
	logic blink_phase_ff;
	logic [`NUM_COMMONS-1:0] common_ff;
	logic [`NUM_SEGMENTS-1:0] segment_ff;
	logic [`NUM_SEGMENTS-1:0] nxt_seg;
	logic [4:0] active_rows;
	logic cur_line;
	logic [3:0] cur_row;
	logic [`CHARS_PER_LINE-1:0] hit;
	logic [`CHARS_PER_LINE-1:0] from_ram;
	logic [4:0] dots [`CHARS_PER_LINE];
	logic [5:0] gidx [`CHARS_PER_LINE];

	// ****************************************
	// access slots
	// ****************************************
	// host and refresh never share a cycle, so a write cannot tear a row
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			slot_ff <= SLOT_REFRESH;
		end else begin
			unique case (slot_ff)
				SLOT_REFRESH: slot_ff <= SLOT_HOST;
				SLOT_HOST: slot_ff <= SLOT_REFRESH;
			endcase
		end
	end

	assign wr_fire = pend_ff && (slot_ff == SLOT_HOST);

	always_comb begin
		nxt_pend = pend_ff;
		if (wr_fire) begin
			nxt_pend = 1'b0;
		end else if (host_we && !pend_ff) begin
			nxt_pend = 1'b1;
		end
	end

	// one write is held until its slot; host_ready low means wait
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_ff <= 1'b0;
			host_ready_ff <= 1'b1;
			pend_pat_ff <= 1'b0;
			pend_addr_ff <= 7'h00;
			pend_data_ff <= 8'h00;
		end else begin
			pend_ff <= nxt_pend;
			host_ready_ff <= !nxt_pend;
			if (host_we && !pend_ff) begin
				pend_pat_ff <= host_to_pattern;
				pend_addr_ff <= host_addr;
				pend_data_ff <= host_wdata;
			end
		end
	end

	// row eleven is stored as written; keeping it zero is the host's job
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 128; i++) begin
				disp_ram_ff[i] <= 8'h00;
			end
			for (int i = 0; i < `USER_GLYPHS*16; i++) begin
				pram_ff[i] <= 5'h00;
			end
		end else if (wr_fire) begin
			if (pend_pat_ff) begin
				pram_ff[pend_addr_ff[5:0]] <= pend_data_ff[4:0];
			end else begin
				disp_ram_ff[pend_addr_ff] <= pend_data_ff;
			end
		end
	end

	// ****************************************
	// common scan
	// ****************************************
	// 5x10 font: one line needs eleven commons, two lines all sixteen
	assign active_rows = two_line ? `ROWS_TWO_LINE : `ROWS_ONE_LINE;
	assign com_step = (com_cnt_ff == COMMON_LAST);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			com_cnt_ff <= '0;
		end else if (com_step) begin
			com_cnt_ff <= '0;
		end else begin
			com_cnt_ff <= com_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			com_idx_ff <= 4'h0;
		end else if (com_step) begin
			if ({1'b0, com_idx_ff} + 5'h01 >= active_rows) begin
				com_idx_ff <= 4'h0;
			end else begin
				com_idx_ff <= com_idx_ff + 4'h1;
			end
		end
	end

	// two lines share sixteen commons: rows 0..6 then the cursor row
	always_comb begin
		cur_line = two_line & com_idx_ff[3];
		cur_row = com_idx_ff;
		if (two_line) begin
			cur_row = (com_idx_ff[2:0] == `LINE_ROWS) ? `CURSOR_ROW :
				{1'b0, com_idx_ff[2:0]};
		end
	end

	assign latch_en = load_ff && (slot_ff == SLOT_REFRESH);

	// commons blank for the step gap so the old row never ghosts
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			load_ff <= 1'b0;
			common_ff <= '0;
			segment_ff <= '0;
		end else if (com_step) begin
			load_ff <= 1'b1;
			common_ff <= '0;
		end else if (latch_en) begin
			load_ff <= 1'b0;
			common_ff <= `NUM_COMMONS'(1) << com_idx_ff;
			segment_ff <= nxt_seg;
		end
	end

	// ****************************************
	// blink timer
	// ****************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			blink_cnt_ff <= '0;
			blink_phase_ff <= 1'b0;
		end else if (blink_cnt_ff == BLINK_LAST) begin
			blink_cnt_ff <= '0;
			blink_phase_ff <= !blink_phase_ff;
		end else begin
			blink_cnt_ff <= blink_cnt_ff + 1'b1;
		end
	end

	// ****************************************
	// glyph and cursor per character
	// ****************************************
	// rom font tables live outside; rom codes show blank here
	for (genvar p = 0; p < `CHARS_PER_LINE; p++) begin : g_char
		logic [6:0] addr;
		logic [7:0] code;
		assign addr = char_addr(cur_line, 5'(p));
		assign code = disp_ram_ff[addr];
		assign from_ram[p] = (code[7:4] == 4'h0);
		assign gidx[p] = glyph_index(code, cur_row);
		// pointer is compared as is; a pattern address lands anywhere
		assign hit[p] = (addr == pointer_counter);
		always_comb begin
			dots[p] = from_ram[p] ? pram_ff[gidx[p]] : `ROM_BLANK;
			if (cursor_en && hit[p] && cur_row == `CURSOR_ROW) begin
				dots[p] = dots[p] | `ALL_DOTS;
			end
			if (blink_en && blink_phase_ff && hit[p]) begin
				dots[p] = `ALL_DOTS;
			end
		end
		assign nxt_seg[p*5 +: 5] = {dots[p][0], dots[p][1], dots[p][2],
			dots[p][3], dots[p][4]};
	end

	assign host_ready = host_ready_ff;
	assign common_out = common_ff;
	assign segment_out = segment_ff;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// the host slot may be the very cycle after the take
	sequence host_take_s;
		host_we && host_ready;
	endsequence
	sequence host_done_s;
		wr_fire ##1 host_ready;
	endsequence
	sequence row_latch_s;
		latch_en && !com_step;
	endsequence
	// the index moves at the step, one or two cycles before the latch
	sequence one_line_held_s;
		!two_line && !$past(two_line) && !$past(two_line, 2);
	endsequence

	host_write_slot_a: assert property (
		wr_fire |-> slot_ff == SLOT_HOST)
		else $error("host write outside host slot");
	host_handshake_a: assert property (
		host_take_s |=> !host_ready ##[0:1] host_done_s)
		else $error("host write not finished in time");
	pattern_keep_a: assert property (
		wr_fire && pend_pat_ff |=>
		pram_ff[$past(pend_addr_ff[5:0])] == $past(pend_data_ff[4:0]))
		else $error("pattern row not stored from low bits");
	refresh_slot_a: assert property (
		$changed(segment_out) |-> $past(slot_ff) == SLOT_REFRESH)
		else $error("segments loaded outside refresh slot");
	seg_hold_a: assert property (
		!latch_en |=> $stable(segment_out))
		else $error("segments changed without a refresh load");
	glyph_index_a: assert property (
		gidx[0] == {disp_ram_ff[char_addr(cur_line, 5'h0)][2:1], cur_row})
		else $error("pattern index wrong");
	code_alias_a: assert property (
		((g_char[0].code ^ g_char[1].code) & 8'hf6) == 8'h00 |->
		gidx[0] == gidx[1])
		else $error("code bits 0 or 3 changed glyph");
	common_onehot_a: assert property (
		$onehot0(common_out))
		else $error("commons not one-hot");
	common_gap_a: assert property (
		com_step |=> common_out == '0)
		else $error("commons not blanked at step");
	common_range_a: assert property (
		row_latch_s ##0 one_line_held_s |=> common_out[15:11] == 5'h00)
		else $error("unused common selected in one-line mode");
	rom_blank_a: assert property (
		row_latch_s ##0 (!from_ram[4] && !hit[4]) |=>
		segment_out[24:20] == 5'h00)
		else $error("rom code not blank");
	dot_order_a: assert property (
		row_latch_s ##0 (from_ram[0] && !hit[0]) |=>
		segment_out[0] == $past(pram_ff[gidx[0]][4]))
		else $error("leftmost dot not from bit 4");
	cursor_row_a: assert property (
		row_latch_s ##0 (cur_row == `CURSOR_ROW && hit[5] && cursor_en) |=>
		segment_out[29:25] == 5'h1f)
		else $error("cursor row not lit");
	blink_dots_a: assert property (
		row_latch_s ##0 (blink_en && blink_phase_ff && hit[0]) |=>
		segment_out[4:0] == 5'h1f)
		else $error("blinking character not lit");
	line_base_a: assert property (
		two_line && com_idx_ff[3] |->
		g_char[0].addr == 7'h40 && g_char[19].addr == 7'h53)
		else $error("second line base wrong");
	line_one_a: assert property (
		!two_line |-> g_char[19].addr == 7'h13)
		else $error("first line end wrong");

endmodule

`default_nettype wire

// [bench/host_model.sv]
// host side model that writes display and pattern RAM one byte at a time
// assumes host_ready is registered on clk; drives 1 ns after a rising edge
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// clock and handshake
	input wire logic clk,
	input wire logic host_ready,
	// write request
	output logic host_we,
	output logic host_to_pattern,
	output logic [6:0] host_addr,
	output logic [7:0] host_wdata
);
	// ****************************************
	// one write, held until taken
	// ****************************************
	initial begin
		host_we = 1'b0;
		host_to_pattern = 1'b0;
		host_addr = 7'h00;
		host_wdata = 8'h00;
	end
	task automatic write(input logic sel, input logic [6:0] a,
		input logic [7:0] d);
		logic r;
		@(posedge clk);
		#1;
		host_we = 1'b1;
		host_to_pattern = sel;
		host_addr = a;
		host_wdata = d;
		// ready is read settled, before the edge at which it is sampled
		do begin
			r = host_ready;
			@(posedge clk);
			#1;
		end while (r !== 1'b1);
		// released lines flip so a stale value is never mistaken for data
		host_we = 1'b0;
		host_to_pattern = ~sel;
		host_addr = ~a;
		host_wdata = ~d;
	endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench of the glyph pattern and cursor generator
// assumes short scan and blink counts; one 40 MHz clock
`timescale 1ns/100ps
`default_nettype none
module testbench;
	// ****************************************
	// signals and reference memories
	// ****************************************
	logic clk, arst_n, two_line, cursor_en, blink_en, host_ready;
	logic host_we, host_to_pattern;
	logic [6:0] host_addr, ptr;
	logic [7:0] host_wdata;
	logic [15:0] common_out;
	logic [99:0] segment_out;
	logic [4:0] pram [64];
	logic [7:0] dram [128];
	int n_mismatch, check_count;
	host_model host (.clk(clk), .host_ready(host_ready), .host_we(host_we),
		.host_to_pattern(host_to_pattern), .host_addr(host_addr),
		.host_wdata(host_wdata));
	char_pattern_cursor_gen #(.BLINK_CYCLES(64), .COMMON_CYCLES(8)) DUT (
		.clk(clk), .arst_n(arst_n), .host_we(host_we),
		.host_to_pattern(host_to_pattern), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_ready(host_ready),
		.two_line(two_line), .cursor_en(cursor_en), .blink_en(blink_en),
		.pointer_counter(ptr), .common_out(common_out),
		.segment_out(segment_out));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [99:0] e, s);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wp(input logic [5:0] a, input logic [4:0] d);
		host.write(1'b1, {1'b0, a}, {3'h7, d});
		pram[a] = d;
	endtask
	task automatic wd(input logic [6:0] a, input logic [7:0] d);
		host.write(1'b0, a, d);
		dram[a] = d;
	endtask
	// blink is left out: tests that look at it compare blink-free rows
	function automatic logic [99:0] exp_row(input int c);
		logic [99:0] v;
		logic [7:0] cd;
		logic [4:0] d;
		int ln, row, a;
		ln = two_line ? c / 8 : 0;
		row = !two_line ? c : (c % 8 == 7) ? 10 : c % 8;
		for (int p = 0; p < 20; p++) begin
			a = ln * 64 + p;
			cd = dram[a];
			d = (cd[7:4] != 4'h0) ? 5'h00 : pram[{cd[2:1], 4'(row)}];
			if (row == 10 && a == ptr && cursor_en) d = d | 5'h1f;
			for (int b = 0; b < 5; b++) v[5 * p + b] = d[4 - b];
		end
		return v;
	endfunction
	// ****************************************
	// scenarios
	// ****************************************
	task automatic scan(input int n);
		logic [15:0] last;
		int w;
		// a common 0 latched before the settings changed does not count
		last = 16'hffff;
		w = 0;
		while (!(common_out === 16'h1 && last === 16'h0) && w < 400) begin
			last = common_out;
			@(posedge clk);
			#1;
			w++;
		end
		for (int k = 0; k <= n; k++) begin
			w = 0;
			while (k > 0 && (common_out === 16'h0 || common_out === last) && w < 40) begin
				@(posedge clk);
				#1;
				w++;
			end
			last = common_out;
			chk("common_out", 100'(16'h1 << (k % n)), 100'(common_out));
			chk("segment_out", exp_row(k % n), segment_out);
		end
	endtask
	task automatic t_reset();
		chk("host_ready", 100'h1, 100'(host_ready));
		chk("common_out", 100'h0, 100'(common_out));
		chk("segment_out", 100'h0, segment_out);
		#1 arst_n = 1'b1;
	endtask
	task automatic t_load();
		for (int r = 0; r < 11; r++) begin
			wp({2'h1, 4'(r)}, r == 10 ? 5'h01 : 5'(r * 7 + 3));
			wp({2'h3, 4'(r)}, r == 10 ? 5'h00 : 5'(~(r * 5)));
		end
		wd(7'h00, 8'h02);
		wd(7'h01, 8'h03);
		wd(7'h02, 8'h0a);
		wd(7'h03, 8'h0b);
		wd(7'h04, 8'h16);
		wd(7'h05, 8'h06);
		wd(7'h06, 8'h0e);
		wd(7'h13, 8'h07);
		wd(7'h40, 8'h03);
		wd(7'h46, 8'h0f);
		wd(7'h53, 8'h16);
	endtask
	task automatic t_lines();
		for (int i = 0; i < 6; i++) begin
			two_line = i[2];
			cursor_en = i[0];
			ptr = i[2] ? (i[1] ? 7'h53 : 7'h46) : (i[1] ? 7'h13 : 7'h05);
			scan(i[2] ? 16 : 11);
		end
	endtask
	task automatic t_blink();
		logic on, off;
		logic [99:0] ref_row;
		two_line = 1'b0;
		cursor_en = 1'b0;
		blink_en = 1'b1;
		ptr = 7'h00;
		ref_row = exp_row(0);
		on = 1'b0;
		off = 1'b0;
		repeat (1500) begin
			@(posedge clk);
			#1;
			if (common_out === 16'h0001 && segment_out[4:0] === 5'h1f) on = 1'b1;
			if (common_out === 16'h0001 && segment_out[4:0] === ref_row[4:0]) off = 1'b1;
		end
		chk("blink phases", 100'h3, {98'h0, on, off});
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		n_mismatch = 0;
		check_count = 0;
		arst_n = 1'b0;
		two_line = 1'b0;
		cursor_en = 1'b0;
		blink_en = 1'b0;
		ptr = 7'h00;
		for (int i = 0; i < 128; i++) dram[i] = 8'h00;
		for (int i = 0; i < 64; i++) pram[i] = 5'h00;
		repeat (10) @(posedge clk);
		t_reset();
		t_load();
		t_lines();
		t_blink();
		tally_and_finish();
	end
	initial begin
		repeat (12000) @(posedge clk);
		n_mismatch++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
